/* hdl/gear_scaler.sv */
// scales a signed stage length by num/den with a serial divider
`timescale 1ns/1ps
`include "mstage_map.svh"
module gear_scaler (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        start_i,
	input  wire logic [31:0] len_i,
	input  wire logic [31:0] num_i,
	input  wire logic [31:0] den_i,
	output logic             done_o,
	output logic [31:0]      result_o
);
	logic [63:0] prod_reg, prod_next;
	logic [32:0] rem_reg, rem_next, rem_sh;
	logic [6:0]  cnt_reg, cnt_next;
	logic        busy_reg, busy_next, neg_reg, neg_next, done_next;
	logic [31:0] res_next, mag;

	// ----------------------------------------
	// multiply once, then divide bit by bit
	// ----------------------------------------
	always_comb begin
		prod_next = prod_reg;
		rem_next  = rem_reg;
		cnt_next  = cnt_reg;
		busy_next = busy_reg;
		neg_next  = neg_reg;
		done_next = 1'b0;
		res_next  = result_o;
		mag       = len_i[31] ? 32'(-len_i) : len_i;
		rem_sh    = {rem_reg[31:0], prod_reg[63]};
		// restart wins so a resumed stage never sees a stale result
		if (start_i) begin
			prod_next = 64'(mag) * 64'(num_i);
			neg_next  = len_i[31];
			rem_next  = 33'h0;
			cnt_next  = `MS_GEAR_STEPS;
			busy_next = 1'b1;
		end else if (busy_reg && cnt_reg == 7'h0) begin
			busy_next = 1'b0;
			done_next = 1'b1;
			if (den_i == 32'h0)
				res_next = 32'h0;
			else
				res_next = neg_reg ? 32'(-prod_reg[31:0]) : prod_reg[31:0];
		end else if (busy_reg) begin
			cnt_next = cnt_reg - 7'h1;
			if (rem_sh >= {1'b0, den_i}) begin
				rem_next  = rem_sh - {1'b0, den_i};
				prod_next = {prod_reg[62:0], 1'b1};
			end else begin
				rem_next  = rem_sh;
				prod_next = {prod_reg[62:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prod_reg <= 64'h0;
			rem_reg  <= 33'h0;
			cnt_reg  <= 7'h0;
			busy_reg <= 1'b0;
			neg_reg  <= 1'b0;
			done_o   <= 1'b0;
			result_o <= 32'h0;
		end else begin
			prod_reg <= prod_next;
			rem_reg  <= rem_next;
			cnt_reg  <= cnt_next;
			busy_reg <= busy_next;
			neg_reg  <= neg_next;
			done_o   <= done_next;
			result_o <= res_next;
		end
	end
endmodule

/* hdl/mstage_sequencer.sv */
// multi-stage internal position command sequencer with wishbone registers
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "mstage_map.svh"
module mstage_sequencer #(
	parameter int MS_CYCLES = `MS_TICK_NS / `MS_CLK_NS,
	parameter int STAGES    = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	input  wire logic        multistage_enable_input_i,
	input  wire logic [3:0]  stage_select_bits_i,
	input  wire logic        dev_clear_i,
	input  wire logic        motion_done_i,
	output logic [31:0]      pos_cmd_o,
	output logic [15:0]      max_speed_o,
	output logic [15:0]      ramp_time_o,
	output logic             cmd_valid_o,
	output logic             pos_done_o,
	output logic             busy_o,
	output logic [3:0]       stage_o
);
	if (STAGES != 16 || MS_CYCLES < 2) begin : g_chk
		$error("mstage_sequencer: unsupported parameters");
	end

	localparam int TW = $clog2(MS_CYCLES);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic       en_s1, en_s2, en_d, clr_s1, clr_s2;
	logic [3:0] sel_s1, sel_s2;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_s1  <= 1'b0;
			en_s2  <= 1'b0;
			en_d   <= 1'b0;
			clr_s1 <= 1'b0;
			clr_s2 <= 1'b0;
			sel_s1 <= 4'h0;
			sel_s2 <= 4'h0;
		end else begin
			en_s1  <= multistage_enable_input_i;
			en_s2  <= en_s1;
			en_d   <= en_s2;
			clr_s1 <= dev_clear_i;
			clr_s2 <= clr_s1;
			sel_s1 <= stage_select_bits_i;
			sel_s2 <= sel_s1;
		end
	end
	logic en_rise;
	assign en_rise = en_s2 & ~en_d;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [31:0] ctrl_reg, ctrl_next, num_reg, num_next, den_reg, den_next;
	logic [3:0]  status_reg, status_next, mask_reg, mask_next, sel_reg, sel_next, ev;
	logic [31:0] dat_next, wmask, pos_reg;
	logic        ack_next, irq_next, go_reg, go_next, acc, wr, rd;
	logic        wr_len, wr_spd, wr_ramp, wr_wait;
	logic [31:0] len_mem  [STAGES];
	logic [15:0] spd_mem  [STAGES];
	logic [15:0] ramp_mem [STAGES];
	logic [15:0] wait_mem [STAGES];
	mstage_pkg::seq_state_t state_reg, state_next;
	logic [3:0]  cur_reg;

	mstage_pkg::pattern_t pat;
	logic [3:0] first_stage_num, last_stage_num, comm_stage;
	logic       resume_pattern_sel, position_type_sel, wait_unit_sel;
	assign pat                = mstage_pkg::pattern_t'(ctrl_reg[`MS_PAT_LSB +: 2]);
	assign resume_pattern_sel = ctrl_reg[`MS_RESUME_BIT];
	assign position_type_sel  = ctrl_reg[`MS_POSTYPE_BIT];
	assign wait_unit_sel      = ctrl_reg[`MS_UNIT_BIT];
	assign first_stage_num    = ctrl_reg[`MS_FIRST_LSB +: 4];
	assign last_stage_num     = ctrl_reg[`MS_LAST_LSB +: 4];
	assign comm_stage         = ctrl_reg[`MS_COMM_LSB +: 4];

	always_comb begin
		acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		wr       = acc & wb_we_i;
		rd       = acc & ~wb_we_i;
		wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		ack_next = acc;
		ctrl_next = ctrl_reg;
		num_next  = num_reg;
		den_next  = den_reg;
		mask_next = mask_reg;
		sel_next  = sel_reg;
		go_next   = 1'b0;
		wr_len    = 1'b0;
		wr_spd    = 1'b0;
		wr_ramp   = 1'b0;
		wr_wait   = 1'b0;
		dat_next  = 32'h0;
		// reading status clears it; a new event in the same cycle survives
		status_next = status_reg | ev;
		if (wb_adr_i == `MS_CTRL_OFS) begin
			dat_next = ctrl_reg;
			if (wr)
				ctrl_next = (ctrl_reg & ~wmask) | (wb_dat_i & wmask);
		end else if (wb_adr_i == `MS_STATUS_OFS) begin
			dat_next = {28'h0, status_reg};
			if (rd)
				status_next = ev;
		end else if (wb_adr_i == `MS_MASK_OFS) begin
			dat_next = {28'h0, mask_reg};
			if (wr && wb_sel_i[0])
				mask_next = wb_dat_i[3:0];
		end else if (wb_adr_i == `MS_GNUM_OFS) begin
			dat_next = num_reg;
			if (wr)
				num_next = (num_reg & ~wmask) | (wb_dat_i & wmask);
		end else if (wb_adr_i == `MS_GDEN_OFS) begin
			dat_next = den_reg;
			if (wr)
				den_next = (den_reg & ~wmask) | (wb_dat_i & wmask);
		end else if (wb_adr_i == `MS_STATE_OFS) begin
			dat_next = {20'h0, 1'(en_s2), 3'(state_reg), 4'(cur_reg), 2'h0, pos_done_o, busy_o};
		end else if (wb_adr_i == `MS_SEL_OFS) begin
			dat_next = {28'h0, sel_reg};
			if (wr && wb_sel_i[0])
				sel_next = wb_dat_i[3:0];
		end else if (wb_adr_i == `MS_LEN_OFS) begin
			dat_next = len_mem[sel_reg];
			wr_len   = wr;
		end else if (wb_adr_i == `MS_SPD_OFS) begin
			dat_next = {16'h0, spd_mem[sel_reg]};
			wr_spd   = wr;
		end else if (wb_adr_i == `MS_RAMP_OFS) begin
			dat_next = {16'h0, ramp_mem[sel_reg]};
			wr_ramp  = wr;
		end else if (wb_adr_i == `MS_WAIT_OFS) begin
			dat_next = {16'h0, wait_mem[sel_reg]};
			wr_wait  = wr;
		end else if (wb_adr_i == `MS_POS_OFS) begin
			dat_next = pos_reg;
		end else if (wb_adr_i == `MS_GO_OFS) begin
			go_next = wr & wb_sel_i[0] & wb_dat_i[0];
		end
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg   <= `MS_CTRL_RST;
			num_reg    <= `MS_GEAR_RST;
			den_reg    <= `MS_GEAR_RST;
			status_reg <= 4'h0;
			mask_reg   <= 4'h0;
			sel_reg    <= 4'h0;
			go_reg     <= 1'b0;
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h0;
			irq_o      <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			num_reg    <= num_next;
			den_reg    <= den_next;
			status_reg <= status_next;
			mask_reg   <= mask_next;
			sel_reg    <= sel_next;
			go_reg     <= go_next;
			wb_ack_o   <= ack_next;
			wb_dat_o   <= dat_next;
			irq_o      <= irq_next;
		end
	end

	// per-stage length, speed, ramp and wait storage
	always_ff @(posedge clk_i) begin
		if (wr_len)
			len_mem[sel_reg] <= (len_mem[sel_reg] & ~wmask) | (wb_dat_i & wmask);
		if (wr_spd)
			spd_mem[sel_reg] <= (spd_mem[sel_reg] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
		if (wr_ramp)
			ramp_mem[sel_reg] <= (ramp_mem[sel_reg] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
		if (wr_wait)
			wait_mem[sel_reg] <= (wait_mem[sel_reg] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
	end

	// ----------------------------------------
	// gear scaling
	// ----------------------------------------
	logic        gstart_reg, gstart_next, gdone;
	logic [31:0] scaled;
	// length times encoder over user pulses per rev
	gear_scaler u_gear (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.start_i  (gstart_reg),
		.len_i    (len_mem[cur_reg]),
		.num_i    (num_reg),
		.den_i    (den_reg),
		.done_o   (gdone),
		.result_o (scaled)
	);

	// ----------------------------------------
	// stage sequencer
	// ----------------------------------------
	logic [3:0]    cur_next, pick;
	logic [31:0]   target_reg, target_next, pos_next, cmd_next;
	logic [15:0]   wcnt_reg, wcnt_next, spd_next, ramp_next;
	logic [TW-1:0] tick_reg, tick_next;
	logic [9:0]    sub_reg, sub_next;
	logic          pw_reg, pw_next, valid_next, done_next, unit_tick, ms_tick;
	logic          running, seq, start;

	always_comb begin
		ms_tick   = tick_reg == TW'(MS_CYCLES - 1);
		// unit select for the wait count
		unit_tick = wait_unit_sel ? (ms_tick && sub_reg == `MS_PER_S) : ms_tick;
		running   = state_reg inside {mstage_pkg::S_SCALE, mstage_pkg::S_ISSUE,
			mstage_pkg::S_MOVE, mstage_pkg::S_WAIT};
		seq       = pat == mstage_pkg::PAT_SINGLE || pat == mstage_pkg::PAT_CYCLIC;
		pick      = seq ? first_stage_num : (pat == mstage_pkg::PAT_INPUT ? sel_s2 : comm_stage);
		start     = pat == mstage_pkg::PAT_COMM ? (go_reg & en_s2) : en_rise;
		state_next  = state_reg;
		cur_next    = cur_reg;
		target_next = target_reg;
		pos_next    = pos_reg;
		cmd_next    = pos_cmd_o;
		spd_next    = max_speed_o;
		ramp_next   = ramp_time_o;
		wcnt_next   = wcnt_reg;
		pw_next     = pw_reg;
		valid_next  = 1'b0;
		done_next   = pos_done_o;
		ev          = 4'h0;
		tick_next   = ms_tick ? TW'(0) : tick_reg + TW'(1);
		sub_next    = ms_tick ? (sub_reg == `MS_PER_S ? 10'h0 : sub_reg + 10'h1) : sub_reg;
		if (clr_s2 && (running || state_reg == mstage_pkg::S_PAUSE)) begin
			state_next = mstage_pkg::S_IDLE;
			ev[`MS_EV_CLEAR] = 1'b1;
		end else if (running && !en_s2) begin
			state_next = mstage_pkg::S_PAUSE;
			pw_next    = state_reg == mstage_pkg::S_WAIT;
			ev[`MS_EV_PAUSE] = 1'b1;
		end else begin
			case (state_reg)
				mstage_pkg::S_IDLE: begin
					if (start) begin
						cur_next   = pick;
						state_next = mstage_pkg::S_SCALE;
					end
				end
				mstage_pkg::S_SCALE: begin
					if (gdone) begin
						target_next = position_type_sel ? scaled : pos_reg + scaled;
						state_next  = mstage_pkg::S_ISSUE;
					end
				end
				mstage_pkg::S_ISSUE: begin
					// hand geared command to filter path
					cmd_next   = target_reg;
					spd_next   = spd_mem[cur_reg];
					ramp_next  = ramp_mem[cur_reg];
					valid_next = 1'b1;
					done_next  = 1'b0;
					state_next = mstage_pkg::S_MOVE;
				end
				mstage_pkg::S_MOVE: begin
					if (motion_done_i) begin
						done_next  = 1'b1;
						pos_next   = target_reg;
						wcnt_next  = wait_mem[cur_reg];
						tick_next  = TW'(0);
						sub_next   = 10'h0;
						ev[`MS_EV_STAGE] = 1'b1;
						state_next = mstage_pkg::S_WAIT;
					end
				end
				mstage_pkg::S_WAIT: begin
					if (wcnt_reg != 16'h0) begin
						if (unit_tick)
							wcnt_next = wcnt_reg - 16'h1;
					end else if (!seq) begin
						state_next = mstage_pkg::S_IDLE;
						ev[`MS_EV_SEQ] = 1'b1;
					end else if (cur_reg != last_stage_num) begin
						cur_next   = cur_reg + 4'h1;
						state_next = mstage_pkg::S_SCALE;
					end else if (pat == mstage_pkg::PAT_CYCLIC) begin
						cur_next   = first_stage_num;
						state_next = mstage_pkg::S_SCALE;
					end else begin
						state_next = mstage_pkg::S_DONE;
						ev[`MS_EV_SEQ] = 1'b1;
					end
				end
				mstage_pkg::S_PAUSE: begin
					if (en_rise) begin
						// resume: rest of stages or from the start
						if (resume_pattern_sel) begin
							cur_next   = pick;
							state_next = mstage_pkg::S_SCALE;
						end else begin
							state_next = pw_reg ? mstage_pkg::S_WAIT : mstage_pkg::S_SCALE;
						end
					end
				end
				mstage_pkg::S_DONE: begin
					if (!en_s2)
						state_next = mstage_pkg::S_IDLE;
				end
				default: state_next = mstage_pkg::S_IDLE;
			endcase
		end
		gstart_next = state_next == mstage_pkg::S_SCALE && state_reg != mstage_pkg::S_SCALE;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg   <= mstage_pkg::S_IDLE;
			cur_reg     <= 4'h0;
			target_reg  <= 32'h0;
			pos_reg     <= 32'h0;
			wcnt_reg    <= 16'h0;
			tick_reg    <= TW'(0);
			sub_reg     <= 10'h0;
			pw_reg      <= 1'b0;
			gstart_reg  <= 1'b0;
			pos_cmd_o   <= 32'h0;
			max_speed_o <= 16'h0;
			ramp_time_o <= 16'h0;
			cmd_valid_o <= 1'b0;
			pos_done_o  <= 1'b0;
			busy_o      <= 1'b0;
			stage_o     <= 4'h0;
		end else begin
			state_reg   <= state_next;
			cur_reg     <= cur_next;
			target_reg  <= target_next;
			pos_reg     <= pos_next;
			wcnt_reg    <= wcnt_next;
			tick_reg    <= tick_next;
			sub_reg     <= sub_next;
			pw_reg      <= pw_next;
			gstart_reg  <= gstart_next;
			pos_cmd_o   <= cmd_next;
			max_speed_o <= spd_next;
			ramp_time_o <= ramp_next;
			cmd_valid_o <= valid_next;
			pos_done_o  <= done_next;
			busy_o      <= state_next != mstage_pkg::S_IDLE && state_next != mstage_pkg::S_DONE;
			stage_o     <= cur_next;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic live, wend;
	assign live = en_s2 & ~clr_s2;
	assign wend = live && state_reg == mstage_pkg::S_WAIT && wcnt_reg == 16'h0;

	sequence s_pause_req;
		running && !en_s2 && !clr_s2;
	endsequence
	sequence s_paused_quiet;
		state_reg == mstage_pkg::S_PAUSE && !cmd_valid_o;
	endsequence

	property p_pause;
		s_pause_req |=> s_paused_quiet;
	endproperty
	a_pause: assert property (p_pause) else $error("enable low did not pause");

	property p_wrap;
		wend && pat == mstage_pkg::PAT_CYCLIC && cur_reg == last_stage_num
			|=> cur_reg == first_stage_num && state_reg == mstage_pkg::S_SCALE;
	endproperty
	a_wrap: assert property (p_wrap) else $error("cyclic run did not wrap");

	property p_single_stop;
		state_reg == mstage_pkg::S_DONE |-> !cmd_valid_o ##1 !cmd_valid_o;
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("command after single pass");

	property p_advance;
		wend && seq && cur_reg != last_stage_num |=> cur_reg == $past(cur_reg) + 4'h1;
	endproperty
	a_advance: assert property (p_advance) else $error("stage did not advance by one");

	property p_wait_hold;
		live && state_reg == mstage_pkg::S_WAIT && wcnt_reg != 16'h0 && !unit_tick
			|=> state_reg == mstage_pkg::S_WAIT && wcnt_reg == $past(wcnt_reg);
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("wait ended early");

	property p_input_pick;
		state_reg == mstage_pkg::S_IDLE && start && pat == mstage_pkg::PAT_INPUT
			|=> cur_reg == $past(sel_s2) && gstart_reg;
	endproperty
	a_input_pick: assert property (p_input_pick) else $error("wrong stage from select code");

	property p_pos_done;
		live && state_reg == mstage_pkg::S_MOVE && motion_done_i
			|=> pos_done_o && state_reg == mstage_pkg::S_WAIT && pos_reg == target_reg;
	endproperty
	a_pos_done: assert property (p_pos_done) else $error("completion not flagged");

	property p_absolute;
		live && state_reg == mstage_pkg::S_SCALE && gdone && position_type_sel
			|=> target_reg == $past(scaled) ##1 cmd_valid_o && pos_cmd_o == target_reg;
	endproperty
	a_absolute: assert property (p_absolute) else $error("absolute target wrong");

	property p_restart;
		state_reg == mstage_pkg::S_PAUSE && live && en_rise && resume_pattern_sel && seq
			|=> cur_reg == first_stage_num && state_reg == mstage_pkg::S_SCALE;
	endproperty
	a_restart: assert property (p_restart) else $error("resume did not restart");
endmodule

/* include/mstage_map.svh */
// register map, field positions, reset values and timing for the stage sequencer
`ifndef MSTAGE_MAP_SVH
`define MSTAGE_MAP_SVH

`define MS_CTRL_OFS     8'h00
`define MS_STATUS_OFS   8'h04
`define MS_MASK_OFS     8'h08
`define MS_GNUM_OFS     8'h0C
`define MS_GDEN_OFS     8'h10
`define MS_STATE_OFS    8'h14
`define MS_SEL_OFS      8'h18
`define MS_LEN_OFS      8'h1C
`define MS_SPD_OFS      8'h20
`define MS_RAMP_OFS     8'h24
`define MS_WAIT_OFS     8'h28
`define MS_POS_OFS      8'h2C
`define MS_GO_OFS       8'h30

`define MS_PAT_LSB      0
`define MS_RESUME_BIT   2
`define MS_POSTYPE_BIT  3
`define MS_UNIT_BIT     4
`define MS_FIRST_LSB    8
`define MS_LAST_LSB     12
`define MS_COMM_LSB     16

`define MS_EV_STAGE     0
`define MS_EV_SEQ       1
`define MS_EV_PAUSE     2
`define MS_EV_CLEAR     3

`define MS_CTRL_RST     32'h0000F000
`define MS_GEAR_RST     32'h00000001

`define MS_CLK_NS       10
`define MS_TICK_NS      1000000
`define MS_PER_S        10'd999
`define MS_GEAR_STEPS   7'h40

`endif

/* include/mstage_pkg.sv */
// types shared by the stage sequencer files
package mstage_pkg;
	typedef enum logic [1:0] {
		PAT_SINGLE,
		PAT_CYCLIC,
		PAT_INPUT,
		PAT_COMM
	} pattern_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_SCALE,
		S_ISSUE,
		S_MOVE,
		S_WAIT,
		S_PAUSE,
		S_DONE
	} seq_state_t;
endpackage

/* test/ctrl_model.sv */
// upper controller model: drives enable and select pins, answers moves
`timescale 1ns/1ps
module ctrl_model (
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [3:0] code_i,
	input  wire logic [7:0] lat_i,
	input  wire logic       cmd_valid_i,
	output logic            enable_o,
	output logic [3:0]      sel_o,
	output logic            motion_done_o
);
	logic [7:0] cnt = 8'h00;
	initial enable_o = 1'b0;
	initial sel_o = 4'h0;
	initial motion_done_o = 1'b0;
	always @(posedge clk_i) begin
		enable_o <= run_i;
		sel_o <= code_i;
		// move ends lat_i cycles after issue, prompt or slow
		motion_done_o <= (cnt == 8'h01);
		if (cmd_valid_i)
			cnt <= lat_i;
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
endmodule

/* test/tb.sv */
// self-checking bench for the stage sequencer
`timescale 1ns/1ps
`include "mstage_map.svh"
module tb;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o, pos, r;
	logic [15:0] spd, ramp;
	logic [3:0]  stg, sel;
	logic [3:0]  code = 4'h0;
	logic        ack, irq, cv, pdone, busy, en, mdone;
	logic        run = 1'b0;
	logic        dclr = 1'b0;
	logic [7:0]  lat = 8'h01;
	logic [31:0] q_pos[$];
	logic [3:0]  q_stg[$];
	logic [3:0]  cs[3];
	logic [31:0] ps[3];
	row_t        rows[6];
	int          n_fail = 0;
	int          n_tests = 0;
	int          cycles = 0;

	always #5 clk_i = ~clk_i;

	mstage_sequencer #(.MS_CYCLES(4), .STAGES(16)) i_mstage_sequencer (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.irq_o(irq), .multistage_enable_input_i(en), .stage_select_bits_i(sel),
		.dev_clear_i(dclr), .motion_done_i(mdone), .pos_cmd_o(pos), .max_speed_o(spd),
		.ramp_time_o(ramp), .cmd_valid_o(cv), .pos_done_o(pdone), .busy_o(busy), .stage_o(stg));

	ctrl_model u_ctrl (.clk_i(clk_i), .run_i(run), .code_i(code), .lat_i(lat),
		.cmd_valid_i(cv), .enable_o(en), .sel_o(sel), .motion_done_o(mdone));

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cv === 1'b1) begin
			q_pos.push_back(pos);
			q_stg.push_back(stg);
		end
		// a hung wait ends the run here
		if (cycles == 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic stage(input logic [3:0] i, input logic [31:0] len);
		wb(1'b1, `MS_SEL_OFS, {28'h0, i});
		wb(1'b1, `MS_LEN_OFS, len);
		wb(1'b1, `MS_SPD_OFS, 32'h00000064);
		wb(1'b1, `MS_RAMP_OFS, 32'h00000005);
		wb(1'b1, `MS_WAIT_OFS, 32'h00000001);
	endtask

	task automatic exp_cmd(input logic [31:0] p, input logic [3:0] s);
		int t;
		t = 0;
		while (q_pos.size() == 0 && t < 400) begin
			@(posedge clk_i);
			t++;
		end
		chk("cmd count", 32'h1, (q_pos.size() != 0) ? 32'h1 : 32'h0);
		if (q_pos.size() != 0) begin
			chk("pos", p, q_pos.pop_front());
			chk("stage", {28'h0, s}, {28'h0, q_stg.pop_front()});
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rows = '{'{`MS_GNUM_OFS, 32'h2, 32'h2}, '{`MS_GDEN_OFS, 32'h1, 32'h1},
			'{`MS_MASK_OFS, 32'hF, 32'hF}, '{`MS_SEL_OFS, 32'h5, 32'h5},
			'{`MS_LEN_OFS, 32'h80000000, 32'h80000000}, '{8'h40, 32'hDEADBEEF, 32'h0}};
		cs = '{4'h0, 4'h2, 4'hF};
		ps = '{32'h14, 32'hE, 32'h6};
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, `MS_CTRL_OFS, 32'h0);
		chk("ctrl reset", `MS_CTRL_RST, r);
		wb(1'b0, `MS_GDEN_OFS, 32'h0);
		chk("gden reset", `MS_GEAR_RST, r);
		chk("irq reset", 32'h0, {31'h0, irq});
		foreach (rows[k]) begin
			wb(1'b1, rows[k].a, rows[k].d);
			wb(1'b0, rows[k].a, 32'h0);
			chk("reg", rows[k].e, r);
		end
		stage(4'h0, 32'hA);
		stage(4'h1, 32'hFFFFFFFD);
		stage(4'h2, 32'h7);
		stage(4'hF, 32'h3);
		wb(1'b1, `MS_CTRL_OFS, 32'h00002000);
		run <= 1'b1;
		exp_cmd(32'h14, 4'h0);
		chk("speed", 32'h64, {16'h0, spd});
		chk("ramp", 32'h5, {16'h0, ramp});
		exp_cmd(32'hE, 4'h1);
		exp_cmd(32'h1C, 4'h2);
		repeat (300) @(posedge clk_i);
		chk("extra cmds", 32'h0, q_pos.size());
		chk("pos done", 32'h1, {31'h0, pdone});
		chk("irq set", 32'h1, {31'h0, irq});
		wb(1'b0, `MS_STATUS_OFS, 32'h0);
		chk("status", 32'h3, r);
		repeat (3) @(posedge clk_i);
		chk("irq clear", 32'h0, {31'h0, irq});
		run <= 1'b0;
		lat <= 8'h28;
		repeat (8) @(posedge clk_i);
		wb(1'b1, `MS_CTRL_OFS, 32'h0000210D);
		run <= 1'b1;
		exp_cmd(32'hFFFFFFFA, 4'h1);
		exp_cmd(32'hE, 4'h2);
		exp_cmd(32'hFFFFFFFA, 4'h1);
		exp_cmd(32'hE, 4'h2);
		run <= 1'b0;
		repeat (20) @(posedge clk_i);
		q_pos.delete();
		q_stg.delete();
		wb(1'b0, `MS_STATUS_OFS, 32'h0);
		chk("paused", 32'h4, r & 32'h4);
		run <= 1'b1;
		exp_cmd(32'hFFFFFFFA, 4'h1);
		dclr <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("abort busy", 32'h0, {31'h0, busy});
		dclr <= 1'b0;
		run <= 1'b0;
		lat <= 8'h01;
		wb(1'b0, `MS_STATUS_OFS, 32'h0);
		chk("clear abort", 32'h8, r & 32'h8);
		q_pos.delete();
		q_stg.delete();
		wb(1'b1, `MS_CTRL_OFS, 32'h0000000A);
		foreach (cs[k]) begin
			code <= cs[k];
			repeat (4) @(posedge clk_i);
			run <= 1'b1;
			exp_cmd(ps[k], cs[k]);
			repeat (10) @(posedge clk_i);
			run <= 1'b0;
			repeat (8) @(posedge clk_i);
		end
		wb(1'b1, `MS_CTRL_OFS, 32'h0001000B);
		run <= 1'b1;
		repeat (6) @(posedge clk_i);
		wb(1'b1, `MS_GO_OFS, 32'h1);
		exp_cmd(32'hFFFFFFFA, 4'h1);
		run <= 1'b0;
		print_verdict();
	end
endmodule
